// ==== rtl/serprog_regs.svh ====
// constants of the serial memory programming port
// assumes a 40 MHz core clock; included by the package and by the top port module
`ifndef SERPROG_REGS_SVH
`define SERPROG_REGS_SVH

// ****************************************************
// instruction codes
// ****************************************************
`define SP_OP_ENABLE 8'hAC
`define SP_ENABLE_ECHO 8'h53
`define SP_ERASE_TOP 3'h4
`define SP_OP_LD_EXT 8'h4D
`define SP_OP_WR_PAGE 8'h4C
`define SP_OP_RD_EE 8'hA0
`define SP_OP_WR_EE 8'hC0
`define SP_OP_POLL 8'hF0
`define SP_NIB_RD_FLASH 4'h2
`define SP_NIB_LD_PAGE 4'h4
`define SP_H_LOW_ZERO 3'h0
`define SP_ERASED_BYTE 8'hFF
`define SP_ERASED_WORD 16'hFFFF

// ****************************************************
// timing
// ****************************************************
`define SP_CORE_KHZ 40000
`define SP_SCK_PHASE_MIN_CYC 3
`define SP_PAGE_WAIT_US 4500
`define SP_EE_WAIT_US 9000
`define SP_ERASE_WAIT_US 9000
`define SP_US_TO_CYC(us) (((us) * `SP_CORE_KHZ + 999) / 1000)

`endif

// ==== rtl/serprog_pkg.sv ====
// types shared by the serial programming port modules
// assumes serprog_regs.svh on the include path
package serprog_pkg;
  `include "serprog_regs.svh"

  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_PROG_EN,
    CMD_ERASE,
    CMD_LD_EXT,
    CMD_RD_FLASH,
    CMD_LD_PAGE,
    CMD_WR_PAGE,
    CMD_RD_EE,
    CMD_WR_EE,
    CMD_POLL
  } cmd_e;

  // classify an instruction from its first two bytes
  function automatic cmd_e decodeCmd(input logic [7:0] b1,
                                     input logic [7:0] b2);
    cmd_e c;
    c = CMD_NONE;
    if (b1 == `SP_OP_ENABLE && b2 == `SP_ENABLE_ECHO)
      c = CMD_PROG_EN;
    else if (b1 == `SP_OP_ENABLE && b2[7:5] == `SP_ERASE_TOP)
      c = CMD_ERASE;
    else if (b1 == `SP_OP_LD_EXT && b2 == 8'h00)
      c = CMD_LD_EXT;
    else if (b1 == `SP_OP_WR_PAGE)
      c = CMD_WR_PAGE;
    else if (b1[7:4] == `SP_NIB_RD_FLASH && b1[2:0] == `SP_H_LOW_ZERO)
      c = CMD_RD_FLASH;
    else if (b1[7:4] == `SP_NIB_LD_PAGE && b1[2:0] == `SP_H_LOW_ZERO)
      c = CMD_LD_PAGE;
    else if (b1 == `SP_OP_RD_EE)
      c = CMD_RD_EE;
    else if (b1 == `SP_OP_WR_EE)
      c = CMD_WR_EE;
    else if (b1 == `SP_OP_POLL)
      c = CMD_POLL;
    return c;
  endfunction
endpackage

// ==== rtl/serprog_mem_array.sv ====
// flip-flop storage array with one write port, erase-all and a read port
// assumes writes come from the core clock domain only
`timescale 1ns/1ps
module serprog_mem_array #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic eraseAll,
  // read side
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] cells;
  } mem_s;

  mem_s mem_reg;
  mem_s mem_next;

  // contents are nonvolatile data, so no reset on purpose
  always_comb
  begin
    mem_next = mem_reg;
    if (eraseAll)
      mem_next.cells = '1;
    else if (wrEn)
      mem_next.cells[wrAddr] = wrData;
  end

  always_ff @(posedge clk)
  begin
    mem_reg <= mem_next;
  end

  assign rdData = mem_reg.cells[rdAddr];
endmodule // serprog_mem_array

// ==== rtl/serprog_link_shift.sv ====
// serial-clock side: shifts instructions in and answers out
// assumes the serial clock stands still outside frames; linkClr is the
// reset pin level and clears this logic whenever programming mode ends
`timescale 1ns/1ps
module serprog_link_shift (
  // link clock and clear
  input wire logic serialClk,
  input wire logic linkClr,
  // pins
  input wire logic serial_prog_data_in,
  output logic serial_prog_data_out,
  // core side
  input wire logic busyAsync,
  input wire logic [15:0] flashWord,
  input wire logic [7:0] eeByte,
  output logic [23:0] header,
  output logic [31:0] cmdWord,
  output logic cmdToggle
);
  typedef struct packed {
    logic [31:0] shift;
    logic [4:0] bitCnt;
    logic [31:0] word;
    logic tgl;
    logic busyMeta;
    logic busySync;
    logic [7:0] outByte;
    logic outBit;
  } link_s;

  link_s rise_reg, rise_next, fall_reg, fall_next;
  serprog_pkg::cmd_e hdrCmd;
  logic [7:0] reply;
  logic [7:0] loadByte;

  assign header = rise_reg.shift[23:0];
  assign hdrCmd = serprog_pkg::decodeCmd(header[23:16], header[15:8]);

  // ****************************************************
  // rising edge: sample input
  // ****************************************************
  always_comb
  begin
    rise_next = rise_reg;
    rise_next.shift = {rise_reg.shift[30:0], serial_prog_data_in};
    rise_next.bitCnt = rise_reg.bitCnt + 5'd1;
    rise_next.busyMeta = busyAsync;
    rise_next.busySync = rise_reg.busyMeta;
    if (rise_reg.bitCnt == 5'd31)
    begin
      rise_next.word = rise_next.shift;
      rise_next.tgl = ~rise_reg.tgl;
    end
  end

  // ****************************************************
  // falling edge: drive output
  // ****************************************************
  // memory read paths are quasi-static: they must not change during a read
  always_comb
  begin
    case (hdrCmd)
      serprog_pkg::CMD_RD_FLASH:
        reply = header[19] ? flashWord[15:8] : flashWord[7:0];
      serprog_pkg::CMD_RD_EE:
        reply = eeByte;
      serprog_pkg::CMD_POLL:
        reply = {7'h00, rise_reg.busySync};
      default:
        reply = 8'h00;
    endcase
    if (rise_reg.bitCnt[4:3] == 2'd0)
      loadByte = 8'h00;
    else if (rise_reg.bitCnt[4:3] == 2'd3)
      loadByte = reply;
    else
      loadByte = rise_reg.shift[7:0];
    fall_next = fall_reg;
    if (rise_reg.bitCnt[2:0] == 3'd0)
    begin
      fall_next.outByte = loadByte;
      fall_next.outBit = loadByte[7];
    end
    else
      fall_next.outBit = fall_reg.outByte[~rise_reg.bitCnt[2:0]];
  end

  always_ff @(posedge serialClk or posedge linkClr)
  begin
    if (linkClr)
      rise_reg <= '0;
    else
      rise_reg <= rise_next;
  end

  always_ff @(negedge serialClk or posedge linkClr)
  begin
    if (linkClr)
      fall_reg <= '0;
    else
      fall_reg <= fall_next;
  end

  assign serial_prog_data_out = fall_reg.outBit;
  assign cmdWord = rise_reg.word;
  assign cmdToggle = rise_reg.tgl;
endmodule // serprog_link_shift

// ==== rtl/serial_memory_programming_port.sv ====
// reset-held serial programming port: decoder, page buffer, timed writes
// assumes core_clk runs while the reset pin is low; the programmer keeps
// serial clock phases and wait times, so storage is quiet during reads
`timescale 1ns/1ps
`include "serprog_regs.svh"
module serial_memory_programming_port #(
  parameter int FLASH_AW = 16,
  parameter int EE_AW = 12,
  parameter int PAGE_AW = 6,
  parameter int TW = 20,
  parameter int PAGE_WAIT_CYC = `SP_US_TO_CYC(`SP_PAGE_WAIT_US),
  parameter int EE_WAIT_CYC = `SP_US_TO_CYC(`SP_EE_WAIT_US),
  parameter int ERASE_WAIT_CYC = `SP_US_TO_CYC(`SP_ERASE_WAIT_US)
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // programming pins
  input wire logic pinReset_b,
  input wire logic serialClk,
  input wire logic serial_prog_data_in,
  output logic serial_prog_data_out,
  // status
  output logic progEnabled,
  output logic operation_in_progress_flag
);
  localparam int PAGE_WORDS = 1 << PAGE_AW;
  localparam logic [TW-1:0] PAGE_WAIT = TW'(PAGE_WAIT_CYC);
  localparam logic [TW-1:0] EE_WAIT = TW'(EE_WAIT_CYC);
  localparam logic [TW-1:0] ERASE_WAIT = TW'(ERASE_WAIT_CYC);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_COPY = 3'b010,
    S_TIMED = 3'b100
  } state_e;

  typedef struct packed {
    logic pinMeta;
    logic pinSync;
    logic tglMeta;
    logic tglSync;
    logic tglSeen;
    logic progEn;
    logic [7:0] extAddr;
    state_e state;
    logic [TW-1:0] timer;
    logic eeOp;
    logic [PAGE_AW-1:0] copyIdx;
    logic [23:0] pageBase;
    logic [EE_AW-1:0] eeAddr;
    logic [7:0] eeData;
    logic [PAGE_WORDS-1:0][15:0] page;
  } core_s;

  core_s core_reg;
  core_s core_next;

  // ****************************************************
  // link side
  // ****************************************************
  logic [23:0] header;
  logic [31:0] cmdWord;
  logic cmdToggle;
  logic [15:0] flashRdWord;
  logic [7:0] eeRdByte;
  logic [23:0] flashRdAddr;

  // the reset pin level clears the shift state asynchronously
  serprog_link_shift u_link (
    .serialClk(serialClk),
    .linkClr(pinReset_b),
    .serial_prog_data_in(serial_prog_data_in),
    .serial_prog_data_out(serial_prog_data_out),
    .busyAsync(operation_in_progress_flag),
    .flashWord(flashRdWord),
    .eeByte(eeRdByte),
    .header(header),
    .cmdWord(cmdWord),
    .cmdToggle(cmdToggle)
  );

  // ****************************************************
  // storage
  // ****************************************************
  logic flWrEn;
  logic [23:0] flWrAddr;
  logic [15:0] flWrData;
  logic eeWrEn;
  logic [7:0] eeWrData;
  logic eraseAll;

  // program reads address c:a:b with the retained extended byte
  assign flashRdAddr = {core_reg.extAddr, header[15:0]};

  serprog_mem_array #(
    .AW(FLASH_AW),
    .DW(16)
  ) u_flash (
    .clk(core_clk),
    .wrEn(flWrEn),
    .wrAddr(flWrAddr[FLASH_AW-1:0]),
    .wrData(flWrData),
    .eraseAll(eraseAll),
    .rdAddr(flashRdAddr[FLASH_AW-1:0]),
    .rdData(flashRdWord)
  );

  serprog_mem_array #(
    .AW(EE_AW),
    .DW(8)
  ) u_eeprom (
    .clk(core_clk),
    .wrEn(eeWrEn),
    .wrAddr(core_reg.eeAddr),
    .wrData(eeWrData),
    .eraseAll(eraseAll),
    .rdAddr(header[EE_AW-1:0]),
    .rdData(eeRdByte)
  );

  // ****************************************************
  // instruction decode and timed operations
  // ****************************************************
  logic newWord;
  logic [7:0] b1, b2, b3, b4;
  serprog_pkg::cmd_e cmd;
  logic [23:0] reqAddr;

  assign b1 = cmdWord[31:24];
  assign b2 = cmdWord[23:16];
  assign b3 = cmdWord[15:8];
  assign b4 = cmdWord[7:0];
  assign cmd = serprog_pkg::decodeCmd(b1, b2);
  assign reqAddr = {core_reg.extAddr, b2, b3};

  always_comb
  begin
    core_next = core_reg;
    flWrEn = 1'b0;
    flWrAddr = 24'h00_0000;
    flWrData = `SP_ERASED_WORD;
    eeWrEn = 1'b0;
    eeWrData = `SP_ERASED_BYTE;
    eraseAll = 1'b0;

    // reset pin and word toggle each cross through two flops
    core_next.pinMeta = pinReset_b;
    core_next.pinSync = core_reg.pinMeta;
    core_next.tglMeta = cmdToggle;
    core_next.tglSync = core_reg.tglMeta;
    newWord = core_reg.tglSync != core_reg.tglSeen;
    if (newWord)
      core_next.tglSeen = core_reg.tglSync;

    // leaving programming mode forgets the enable
    if (core_reg.pinSync)
      core_next.progEn = 1'b0;

    case (core_reg.state)
      S_IDLE:
      begin
        if (newWord && !core_reg.pinSync)
        begin
          if (cmd == serprog_pkg::CMD_PROG_EN)
            core_next.progEn = 1'b1;
          else if (core_reg.progEn)
          begin
            case (cmd)
              serprog_pkg::CMD_LD_EXT:
                core_next.extAddr = b3;
              serprog_pkg::CMD_LD_PAGE:
              begin
                // each half is written alone, so low then high builds a word
                if (b1[3])
                  core_next.page[b3[PAGE_AW-1:0]][15:8] = b4;
                else
                  core_next.page[b3[PAGE_AW-1:0]][7:0] = b4;
              end
              serprog_pkg::CMD_WR_PAGE:
              begin
                core_next.pageBase = (reqAddr >> PAGE_AW) << PAGE_AW;
                core_next.copyIdx = '0;
                core_next.state = S_COPY;
              end
              serprog_pkg::CMD_WR_EE:
              begin
                core_next.eeAddr = reqAddr[EE_AW-1:0];
                core_next.eeData = b4;
                core_next.eeOp = 1'b1;
                core_next.timer = EE_WAIT;
                core_next.state = S_TIMED;
              end
              serprog_pkg::CMD_ERASE:
              begin
                eraseAll = 1'b1;
                core_next.page = '1;
                core_next.eeOp = 1'b0;
                core_next.timer = ERASE_WAIT;
                core_next.state = S_TIMED;
              end
              default:
              begin
                core_next.extAddr = core_reg.extAddr;
              end
            endcase
          end
        end
      end

      // one buffer word per core cycle into the page
      S_COPY:
      begin
        flWrEn = 1'b1;
        flWrAddr = core_reg.pageBase + 24'(core_reg.copyIdx);
        flWrData = core_reg.page[core_reg.copyIdx];
        core_next.page[core_reg.copyIdx] = `SP_ERASED_WORD;
        core_next.copyIdx = core_reg.copyIdx + 1'b1;
        if (core_reg.copyIdx == PAGE_AW'(PAGE_WORDS - 1))
        begin
          core_next.eeOp = 1'b0;
          core_next.timer = PAGE_WAIT;
          core_next.state = S_TIMED;
        end
      end

      // the first cycle of an eeprom write erases the byte, the last
      // one stores the data
      S_TIMED:
      begin
        if (core_reg.eeOp && core_reg.timer == EE_WAIT)
          eeWrEn = 1'b1;
        core_next.timer = core_reg.timer - 1'b1;
        if (core_reg.timer <= TW'(1))
        begin
          if (core_reg.eeOp)
          begin
            eeWrEn = 1'b1;
            eeWrData = core_reg.eeData;
          end
          core_next.eeOp = 1'b0;
          core_next.timer = '0;
          core_next.state = S_IDLE;
        end
      end

      default:
        core_next.state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      core_reg <= '0;
      core_reg.pinMeta <= 1'b1;
      core_reg.pinSync <= 1'b1;
      core_reg.extAddr <= 8'h00;
      core_reg.state <= S_IDLE;
      core_reg.page <= '1;
    end
    else
      core_reg <= core_next;
  end

  assign progEnabled = core_reg.progEn;
  assign operation_in_progress_flag = core_reg.state != S_IDLE;
endmodule // serial_memory_programming_port

// ==== verification/serprog_port_assertions.sv ====
// checker for the serial programming port, bound to its top ports
// assumes the programmer keeps serial clock phases above three core cycles
`timescale 1ns/1ps
module serprog_port_checker #(
  parameter int PAGE_AW = 6,
  parameter int PAGE_WAIT_CYC = 20,
  parameter int EE_WAIT_CYC = 20,
  parameter int ERASE_WAIT_CYC = 20
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // pins
  input wire logic pinReset_b,
  input wire logic serialClk,
  input wire logic serial_prog_data_out,
  // status
  input wire logic progEnabled,
  input wire logic operation_in_progress_flag
);
  // ****************************************************
  // busy length counter
  // ****************************************************
  // loose upper bound: any timed operation must end by then
  localparam int MAXW = ERASE_WAIT_CYC + EE_WAIT_CYC + PAGE_WAIT_CYC
    + 2 ** PAGE_AW;
  logic [19:0] busyCnt_reg;
  always_ff @(posedge core_clk)
    if (!rst_b || !operation_in_progress_flag)
      busyCnt_reg <= 20'h0_0000;
    else
      busyCnt_reg <= busyCnt_reg + 20'h0_0001;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_OUT_FALL: assert property (!$stable(serial_prog_data_out) |->
    (!serialClk || pinReset_b)) else $error("data out moved off fall");
  AST_OUT_PIN: assert property (pinReset_b && $past(pinReset_b) |->
    !serial_prog_data_out) else $error("data out not clear");
  AST_EN_CLEAR: assert property ($rose(pinReset_b) |->
    ##[1:4] !progEnabled) else $error("enable kept after pin high");
  AST_EN_NEEDS_PIN: assert property ($rose(progEnabled) |->
    !pinReset_b && !$past(pinReset_b, 3)) else $error("enable off mode");
  AST_EN_FALL: assert property ($fell(progEnabled) |->
    $past(pinReset_b) || $past(pinReset_b, 2) || $past(pinReset_b, 3))
    else $error("enable dropped without pin");
  AST_BUSY_NEEDS_EN: assert property ($rose(operation_in_progress_flag)
    |-> progEnabled && !pinReset_b) else $error("busy while not enabled");
  AST_BUSY_MIN: assert property ($fell(operation_in_progress_flag) |->
    busyCnt_reg >= PAGE_WAIT_CYC) else $error("timed operation too short");
  AST_BUSY_MAX: assert property (operation_in_progress_flag |->
    busyCnt_reg <= MAXW) else $error("timed operation never ends");

  COV_ENABLE: cover property ($rose(progEnabled));
  COV_LEAVE: cover property ($fell(progEnabled));
  COV_TIMED_OP: cover property ($fell(operation_in_progress_flag));
endmodule // serprog_port_checker

bind serial_memory_programming_port serprog_port_checker #(
  .PAGE_AW(PAGE_AW), .PAGE_WAIT_CYC(PAGE_WAIT_CYC),
  .EE_WAIT_CYC(EE_WAIT_CYC), .ERASE_WAIT_CYC(ERASE_WAIT_CYC)
) i_serprog_port_checker (
  .core_clk(core_clk), .rst_b(rst_b), .pinReset_b(pinReset_b),
  .serialClk(serialClk), .serial_prog_data_out(serial_prog_data_out),
  .progEnabled(progEnabled),
  .operation_in_progress_flag(operation_in_progress_flag)
);

// ==== verification/serprog_programmer_model.sv ====
// behavioural in-system programmer: clocks whole instructions in and out
// assumes the bench calls xfer for every instruction, one at a time
`timescale 1ns/1ps
module serprog_programmer_model #(
  parameter int HALF_NS = 80
) (
  // serial pins
  output logic serialClk,
  output logic serial_prog_data_in,
  input wire logic serial_prog_data_out
);
  initial
  begin
    serialClk = 1'b0;
    serial_prog_data_in = 1'b0;
  end

  // always four bytes, msb first; clock stands low between frames
  task automatic xfer(input logic [31:0] word, output logic [31:0] reply);
    for (int i = 31; i >= 0; i--)
    begin
      serial_prog_data_in = word[i];
      #(HALF_NS);
      serialClk = 1'b1;
      reply[i] = serial_prog_data_out;
      #(HALF_NS);
      serialClk = 1'b0;
    end
    // released line must not look like a held bit
    serial_prog_data_in = ~word[0];
    #(HALF_NS * 4);
  endtask
endmodule // serprog_programmer_model

// ==== verification/tb_top.sv ====
// self-checking bench for the serial programming port
// assumes the programmer model drives the serial pins; waits are shortened
`timescale 1ns/1ps
module tb_top;
  localparam int PG_W = 200;
  localparam int EE_W = 400;
  logic core_clk;
  logic rst_b;
  logic pinReset_b;
  logic serialClk;
  logic sdi;
  logic serial_prog_data_out;
  logic progEnabled;
  logic operation_in_progress_flag;
  logic [31:0] rsp;
  int error_cnt = 0;
  int tests_run = 0;
  int polls;

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  serial_memory_programming_port #(.FLASH_AW(8), .EE_AW(6),
    .PAGE_WAIT_CYC(PG_W), .EE_WAIT_CYC(EE_W), .ERASE_WAIT_CYC(EE_W)
  ) i_serial_memory_programming_port (
    .core_clk(core_clk), .rst_b(rst_b), .pinReset_b(pinReset_b),
    .serialClk(serialClk), .serial_prog_data_in(sdi),
    .serial_prog_data_out(serial_prog_data_out), .progEnabled(progEnabled),
    .operation_in_progress_flag(operation_in_progress_flag));

  serprog_programmer_model i_serprog_programmer_model (
    .serialClk(serialClk), .serial_prog_data_in(sdi),
    .serial_prog_data_out(serial_prog_data_out));

  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic cmd(input logic [31:0] w);
    i_serprog_programmer_model.xfer(w, rsp);
  endtask

  task automatic rd(input logic [31:0] w, input logic [7:0] ex);
    cmd(w);
    check(rsp[7:0] === ex, "read data");
  endtask

  task automatic pinPulse();
    @(posedge core_clk);
    pinReset_b <= 1'b1;
    repeat (10) @(posedge core_clk);
    pinReset_b <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic waitIdle();
    polls = 0;
    do
    begin
      cmd(32'hF000_0000);
      polls++;
    end
    while (rsp[0] !== 1'b0 && polls < 20);
    check(rsp[7:0] === 8'h00, "poll not idle");
    check(operation_in_progress_flag === 1'b0, "busy stuck");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic testRefused();
    cmd(32'hC000_0511);
    check(operation_in_progress_flag === 1'b0, "write taken");
    cmd(32'hAC80_0000);
    check(operation_in_progress_flag === 1'b0, "erase taken");
    check(progEnabled === 1'b0, "enabled early");
    $display("test refused done");
  endtask

  task automatic testEnable();
    cmd(32'hAC53_0000);
    check(rsp[15:8] === 8'h53, "no echo");
    check(progEnabled === 1'b1, "not enabled");
    pinPulse();
    check(progEnabled === 1'b0, "enable kept");
    cmd(32'hAC54_0000);
    check(rsp[15:8] !== 8'h53, "false echo");
    check(progEnabled === 1'b0, "bad enable");
    pinPulse();
    cmd(32'hAC53_5AA5);
    check(rsp[15:8] === 8'h53, "no echo");
    check(progEnabled === 1'b1, "not enabled");
    $display("test enable done");
  endtask

  task automatic testErase();
    cmd(32'hAC9F_FFFF);
    check(operation_in_progress_flag === 1'b1, "erase idle");
    waitIdle();
    check(polls > 1, "poll missed busy");
    rd(32'hA000_0500, 8'hFF);
    rd(32'hA000_3F00, 8'hFF);
    rd(32'h2000_FF00, 8'hFF);
    rd(32'h2800_0000, 8'hFF);
    $display("test erase done");
  endtask

  task automatic testEeprom();
    cmd(32'hC000_05A5);
    check(operation_in_progress_flag === 1'b1, "write idle");
    waitIdle();
    rd(32'hA000_0500, 8'hA5);
    // complementary data shows that the second write replaces every bit of the first
    cmd(32'hC000_055A);
    waitIdle();
    rd(32'hA000_0500, 8'h5A);
    $display("test eeprom done");
  endtask

  task automatic testPage();
    logic [31:0] adr [5] = '{32'h2000_4300, 32'h2800_4300, 32'h2000_4700,
      32'h2800_4700, 32'h2000_0300};
    logic [7:0] ex [5] = '{8'h34, 8'h12, 8'h99, 8'hFF, 8'hFF};
    cmd(32'h4000_0334);
    cmd(32'h4800_0312);
    cmd(32'h4000_0799);
    cmd(32'h4D00_0000);
    cmd(32'h4C00_4000);
    check(operation_in_progress_flag === 1'b1, "page idle");
    waitIdle();
    for (int i = 0; i < 5; i++)
      rd(adr[i], ex[i]);
    $display("test page done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    pinReset_b = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    // power-up wait shortened: no timer in the model depends on it
    pinReset_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    testRefused();
    testEnable();
    testErase();
    testEeprom();
    testPage();
    results();
  end

  initial
  begin
    #1_000_000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule // tb_top
